// ==== dv/rc_osc_model.sv ====
// RC oscillator tick source with a count of ticks seen during each operation
module rc_osc_model #(
    parameter int DIV = 50
) (
    // Clock
    input wire logic mclk_i,
    // Tick and observation
    input wire logic active_i,
    output logic tick_o,
    output int ticks_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    logic act_q = 1'b0;
    initial tick_o = 1'b0;
    initial ticks_o = 0;
    // One tick per oscillator period, every DIV cycles of the CPU clock
    always @(posedge mclk_i) begin
        cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
        tick_o <= (cnt == DIV - 1);
        act_q <= active_i;
        if (active_i && !act_q) begin
            ticks_o <= tick_o ? 1 : 0;
        end else if (active_i && tick_o) begin
            ticks_o <= ticks_o + 1;
        end
    end
endmodule : rc_osc_model

// ==== dv/test_flash_self_programming_ctrl.sv ====
// Testbench for the flash self-programming controller
module test_flash_self_programming_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int P = 4;
    logic mclk_i = 1'b0, rst_i = 1'b1, rc_tick_i, ctrl_wr_i = 1'b0, store_i = 1'b0;
    logic boot_size_hi_i = 1'b1, boot_size_lo_i = 1'b1, boot_lock_i = 1'b0, app_lock_i = 1'b0;
    logic eeprom_write_busy_i = 1'b0;
    logic ce_i = 1'b1;
    flash_self_prog_pkg::ctrl_bits_t ctrl_wdata_i = '0, ctrl_rdata_o;
    flash_self_prog_pkg::store_req_t store_req_i = '0;
    logic [15:0] fetch_addr_i = 16'h0000, read_z_i = 16'h0000, read_word_i = 16'h0000;
    logic [15:0] buf_data_o, fill_data = 16'h0000, zb;
    logic section_busy_flag_o, store_refused_o, fetch_allowed_o;
    logic flash_erase_o, flash_write_o, prog_active_o;
    logic [7:0] read_byte_o;
    logic [6:0] flash_page_o;
    logic [5:0] buf_word_o;
    logic [12:0] st [4];
    int failures = 0, checks = 0, ticks, n;

    initial begin
        forever #10 mclk_i = ~mclk_i;
    end

    rc_osc_model osc (.mclk_i(mclk_i), .active_i(prog_active_o), .tick_o(rc_tick_i),
        .ticks_o(ticks));

    flash_self_programming_ctrl #(.PROG_TICKS(P)) uut (
        .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .rc_tick_i(rc_tick_i),
        .ctrl_wr_i(ctrl_wr_i), .ctrl_wdata_i(ctrl_wdata_i), .ctrl_rdata_o(ctrl_rdata_o),
        .section_busy_flag_o(section_busy_flag_o), .store_i(store_i),
        .store_req_i(store_req_i), .store_refused_o(store_refused_o),
        .boot_size_hi_i(boot_size_hi_i), .boot_size_lo_i(boot_size_lo_i),
        .boot_lock_i(boot_lock_i), .app_lock_i(app_lock_i),
        .eeprom_write_busy_i(eeprom_write_busy_i), .fetch_addr_i(fetch_addr_i),
        .fetch_allowed_o(fetch_allowed_o), .read_z_i(read_z_i), .read_word_i(read_word_i),
        .read_byte_o(read_byte_o), .flash_erase_o(flash_erase_o),
        .flash_write_o(flash_write_o), .flash_page_o(flash_page_o), .buf_word_o(buf_word_o),
        .buf_data_o(buf_data_o), .prog_active_o(prog_active_o));

    ////////////////////////////////////////////////////////////////////////////////
    task close_out;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out

    task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task step;
        @(posedge mclk_i);
        #1;
    endtask : step

    task wait_lvl(input logic lvl);
        for (n = 0; n < 1000 && prog_active_o !== lvl; n++) step;
        if (prog_active_o !== lvl) begin
            failures++;
            close_out;
        end
    endtask : wait_lvl

    task fetch(input logic [15:0] a, input logic exp);
        @(posedge mclk_i);
        fetch_addr_i <= a;
        #1 check("fetch", fetch_allowed_o, exp);
    endtask : fetch

    // Arm, optional gap, then the store instruction
    task cmd(input logic [3:0] b, input logic [15:0] z, input int gap, input logic refd);
        @(posedge mclk_i);
        ctrl_wr_i <= 1'b1;
        ctrl_wdata_i <= b;
        @(posedge mclk_i);
        ctrl_wr_i <= 1'b0;
        repeat (gap) @(posedge mclk_i);
        store_i <= 1'b1;
        store_req_i <= {z, fill_data};
        #1 check("refused", store_refused_o, refd);
        @(posedge mclk_i);
        store_i <= 1'b0;
        #1;
    endtask : cmd

    // Full erase or write with timing, blocking and re-enable
    task run(input logic [3:0] b, input logic [15:0] z);
        cmd(b, z, 0, 1'b0);
        wait_lvl(1'b1);
        check("page", flash_page_o, z[13:7]);
        check("erase", flash_erase_o, b[1]);
        check("write", flash_write_o, b[2]);
        check("enable", ctrl_rdata_o.self_prog_enable, 1'b1);
        check("busy", section_busy_flag_o, 1'b1);
        if (b[2]) check("buf", buf_data_o, fill_data);
        if (b[2]) check("bufidx", {10'h000, buf_word_o}, 16'h0000);
        fetch(16'h1BFF, 1'b0);
        fetch(16'h1C00, 1'b1);
        wait_lvl(1'b0);
        check("ticks", ticks >= P && ticks <= P + 1, 1'b1);
        check("idle", ctrl_rdata_o.self_prog_enable, 1'b0);
        fetch(16'h0000, 1'b0);
        cmd(4'b1001, 16'h0000, 0, 1'b0);
        step;
        step;
        check("reen", section_busy_flag_o, 1'b0);
        fetch(16'h0000, 1'b1);
    endtask : run

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        st = '{flash_self_prog_pkg::BOOT_START_00, flash_self_prog_pkg::BOOT_START_01,
            flash_self_prog_pkg::BOOT_START_10, flash_self_prog_pkg::BOOT_START_11};
        repeat (20) @(posedge mclk_i);
        rst_i <= 1'b0;
        step;
        check("rst", {ctrl_rdata_o, section_busy_flag_o}, 16'h0000);
        @(posedge mclk_i);
        read_z_i <= 16'hC001;
        read_word_i <= 16'hA55A;
        step;
        step;
        check("hi", read_byte_o, 8'hA5);
        @(posedge mclk_i);
        read_z_i <= 16'h0000;
        step;
        step;
        check("lo", read_byte_o, 8'h5A);
        $display("test byte read done");
        cmd(4'b0000, 16'h1500, 0, 1'b1);
        cmd(4'b0011, 16'h1500, 4, 1'b1);
        cmd(4'b0001, 16'h1501, 0, 1'b1);
        cmd(4'b0001, 16'h1502, 2, 1'b0);
        @(posedge mclk_i);
        eeprom_write_busy_i <= 1'b1;
        cmd(4'b0001, 16'h1500, 0, 1'b1);
        @(posedge mclk_i);
        eeprom_write_busy_i <= 1'b0;
        $display("test refusals done");
        fill_data = 16'hBEEF;
        cmd(4'b0001, 16'hD500, 0, 1'b0);
        run(4'b0101, 16'hD500);
        run(4'b0011, 16'h1500);
        $display("test write erase done");
        cmd(4'b0011, 16'h1500, 0, 1'b0);
        wait_lvl(1'b1);
        @(posedge mclk_i);
        rst_i <= 1'b1;
        @(posedge mclk_i);
        rst_i <= 1'b0;
        #1 check("keep", flash_erase_o, 1'b1);
        check("enrst", ctrl_rdata_o.self_prog_enable, 1'b1);
        cmd(4'b0001, 16'h1500, 0, 1'b1);
        wait_lvl(1'b0);
        $display("test reset done");
        @(posedge mclk_i);
        ce_i <= 1'b0;
        cmd(4'b0011, 16'h1500, 0, 1'b1);
        check("frozen", prog_active_o, 1'b0);
        @(posedge mclk_i);
        ce_i <= 1'b1;
        $display("test clock enable done");
        boot_lock_i <= 1'b1;
        for (int f = 0; f < 4; f++) begin
            @(posedge mclk_i);
            {boot_size_hi_i, boot_size_lo_i} <= f[1:0];
            zb = {2'b00, st[f], 1'b0};
            cmd(4'b0011, zb, 0, 1'b1);
            run(4'b0011, zb - 16'h0080);
        end
        @(posedge mclk_i);
        boot_lock_i <= 1'b0;
        app_lock_i <= 1'b1;
        cmd(4'b0011, 16'h1500, 0, 1'b1);
        $display("test locks done");
        close_out;
    end
endmodule : test_flash_self_programming_ctrl

// ==== logic/flash_self_prog_pkg.sv ====
// Package with constants and carriers for the flash self-programming controller
// Function
// - A started erase or write runs to completion even through a reset
// - Programming time is counted on the internal RC oscillator tick
// - Each erase or write lasts 3.7 ms to 4.5 ms
// - Boot size fuses pick boot section start 1F80, 1F00, 1E00 or 1C00
// - Readable area is 112 pages 0000-1BFF, halting area 16 pages 1C00-1FFF
// - During erase or write only halting area code may be fetched
// - Program counter is 13 bits addressing 16-bit words
// - A page holds 64 words selected by the low six address bits
// - Page number comes from Z bits 13 to 7
// - Z bits 6 to 1 pick buffer word; zero for page write
// - Z bits 15 and 14 are ignored for all operations
// - Z bit 0 zero for stores; selects byte for program-memory reads
// - Enable bit reads set while a store operation is still running
// - Section busy flag set after erase or write until re-enabled or reset
// - Readable area stays blocked until re-enable command is issued or reset clears the busy flag
// - Store with only enable set loads r1:r0 into page buffer
// - Locked boot section refuses store writes; application section refuses them while app_lock_i is set
package flash_self_prog_pkg;
    localparam int PC_W = 13;
    localparam int PAGE_W = 7;
    localparam int WORD_W = 6;
    localparam int PAGE_WORDS = 64;
    localparam int Z_PAGE_LSB = 7;
    localparam int Z_PAGE_MSB = 13;
    localparam int Z_WORD_LSB = 1;
    localparam int Z_WORD_MSB = 6;
    localparam logic [12:0] HALT_START = 13'h1C00;
    localparam logic [12:0] BOOT_START_11 = 13'h1F80;
    localparam logic [12:0] BOOT_START_10 = 13'h1F00;
    localparam logic [12:0] BOOT_START_01 = 13'h1E00;
    localparam logic [12:0] BOOT_START_00 = 13'h1C00;
    localparam int RC_KHZ = 1000;
    localparam int PROG_MIN_US = 3700;
    localparam int PROG_MAX_US = 4500;
    localparam int PROG_TICKS = (PROG_MIN_US * RC_KHZ + 999) / 1000 + 1;
    localparam int ARM_WINDOW = 4;
    localparam int ARM_CYC_W = 3;

    typedef struct packed {
        logic section_reenable_cmd;
        logic page_write_cmd;
        logic page_erase_cmd;
        logic self_prog_enable;
    } ctrl_bits_t;

    typedef struct packed {
        logic [15:0] z;
        logic [15:0] data;
    } store_req_t;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_ERASE,
        OP_WRITE,
        OP_REENABLE
    } op_t;
endpackage : flash_self_prog_pkg

// ==== logic/flash_self_programming_ctrl.sv ====
// Flash self-programming controller top
module flash_self_programming_ctrl #(
    parameter int PROG_TICKS = flash_self_prog_pkg::PROG_TICKS
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic rc_tick_i,
    // Control register write
    input wire logic ctrl_wr_i,
    input wire flash_self_prog_pkg::ctrl_bits_t ctrl_wdata_i,
    output flash_self_prog_pkg::ctrl_bits_t ctrl_rdata_o,
    output logic section_busy_flag_o,
    // Store instruction
    input wire logic store_i,
    input wire flash_self_prog_pkg::store_req_t store_req_i,
    output logic store_refused_o,
    // Configuration
    input wire logic boot_size_hi_i,
    input wire logic boot_size_lo_i,
    input wire logic boot_lock_i,
    input wire logic app_lock_i,
    input wire logic eeprom_write_busy_i,
    // Fetch and byte reads
    input wire logic [15:0] fetch_addr_i,
    output logic fetch_allowed_o,
    input wire logic [15:0] read_z_i,
    input wire logic [15:0] read_word_i,
    output logic [7:0] read_byte_o,
    // Flash array side
    output logic flash_erase_o,
    output logic flash_write_o,
    output logic [6:0] flash_page_o,
    output logic [5:0] buf_word_o,
    output logic [15:0] buf_data_o,
    output logic prog_active_o
);
    initial begin
        if (PROG_TICKS < 2) begin
            $error("PROG_TICKS too small");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    function automatic logic [12:0] boot_start(input logic hi, input logic lo);
        unique case ({hi, lo})
            2'b11: boot_start = flash_self_prog_pkg::BOOT_START_11;
            2'b10: boot_start = flash_self_prog_pkg::BOOT_START_10;
            2'b01: boot_start = flash_self_prog_pkg::BOOT_START_01;
            2'b00: boot_start = flash_self_prog_pkg::BOOT_START_00;
        endcase
    endfunction : boot_start

    function automatic logic [12:0] z_to_pc(input logic [15:0] z);
        z_to_pc = z[13:1];
    endfunction : z_to_pc

    logic [12:0] boot_base;
    assign boot_base = boot_start(boot_size_hi_i, boot_size_lo_i);

    ////////////////////////////////////////////////////////////////////////
    // Arming window
    flash_self_prog_pkg::ctrl_bits_t armed;
    logic [2:0] arm_cnt;
    logic arm_live;
    assign arm_live = (arm_cnt != 3'h0);

    logic busy_op = 1'b0;
    logic blocked;
    logic timer_done;
    flash_self_prog_pkg::op_t op;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            armed <= '0;
            arm_cnt <= 3'h0;
        end else if (ce_i) begin
            if (ctrl_wr_i && ctrl_wdata_i.self_prog_enable && !busy_op) begin
                armed <= ctrl_wdata_i;
                arm_cnt <= 3'(flash_self_prog_pkg::ARM_WINDOW);
            end else if (store_i || arm_cnt == 3'h1) begin
                armed <= '0;
                arm_cnt <= 3'h0;
            end else if (arm_live) begin
                arm_cnt <= arm_cnt - 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command decode
    logic [12:0] store_pc;
    logic in_boot;
    logic locked;
    assign store_pc = z_to_pc(store_req_i.z);
    assign in_boot = store_pc >= boot_base;
    assign locked = in_boot ? boot_lock_i : app_lock_i;

    always_comb begin
        op = flash_self_prog_pkg::OP_NONE;
        if (armed.page_erase_cmd) begin
            op = flash_self_prog_pkg::OP_ERASE;
        end else if (armed.page_write_cmd) begin
            op = flash_self_prog_pkg::OP_WRITE;
        end else if (armed.section_reenable_cmd) begin
            op = flash_self_prog_pkg::OP_REENABLE;
        end
    end

    logic go;
    assign go = store_i && arm_live && !busy_op && !eeprom_write_busy_i;
    logic start_prog;
    assign start_prog = go && !locked && store_req_i.z[0] == 1'b0
        && (op == flash_self_prog_pkg::OP_ERASE || op == flash_self_prog_pkg::OP_WRITE);
    logic fill;
    assign fill = go && op == flash_self_prog_pkg::OP_NONE && store_req_i.z[0] == 1'b0;
    assign store_refused_o = store_i && !(start_prog || fill
        || (go && op == flash_self_prog_pkg::OP_REENABLE));

    ////////////////////////////////////////////////////////////////////////
    // Operation state, held across reset except the section busy flag, which reset clears
    always_ff @(posedge mclk_i) begin
        if (ce_i) begin
            if (start_prog) begin
                busy_op <= 1'b1;
            end else if (timer_done) begin
                busy_op <= 1'b0;
            end
        end
    end

    logic erase_run = 1'b0;
    logic write_run = 1'b0;
    logic [6:0] page_sel = 7'h00;

    always_ff @(posedge mclk_i) begin
        if (ce_i) begin
            if (start_prog) begin
                page_sel <= store_req_i.z[13:7];
                erase_run <= (op == flash_self_prog_pkg::OP_ERASE);
                write_run <= (op == flash_self_prog_pkg::OP_WRITE);
            end else if (timer_done) begin
                erase_run <= 1'b0;
                write_run <= 1'b0;
            end
        end
    end

    assign flash_erase_o = erase_run;
    assign flash_write_o = write_run;
    assign flash_page_o = page_sel;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            blocked <= 1'b0;
        end else if (ce_i) begin
            if (start_prog || busy_op) begin
                blocked <= 1'b1;
            end else if (go && op == flash_self_prog_pkg::OP_REENABLE) begin
                blocked <= 1'b0;
            end
        end
    end

    rc_prog_timer #(
        .TICKS(PROG_TICKS)
    ) u_timer (
        .mclk_i(mclk_i),
        .ce_i(ce_i),
        .start_i(start_prog),
        .rc_tick_i(rc_tick_i),
        .done_o(timer_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Page buffer
    logic [5:0] word_sel;
    assign word_sel = store_req_i.z[6:1];

    page_buffer_mem #(
        .WIDTH(16),
        .DEPTH(flash_self_prog_pkg::PAGE_WORDS),
        .AW(flash_self_prog_pkg::WORD_W)
    ) u_buf (
        .mclk_i(mclk_i),
        .ce_i(ce_i),
        .wr_i(fill),
        .waddr_i(word_sel),
        .wdata_i(store_req_i.data),
        .raddr_i(buf_word_o),
        .rdata_o(buf_data_o)
    );

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            buf_word_o <= 6'h00;
        end else if (ce_i) begin
            if (start_prog) begin
                buf_word_o <= 6'h00;
            end else if (flash_write_o && rc_tick_i) begin
                buf_word_o <= buf_word_o + 6'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fetch gate and byte read
    logic fetch_halt_area;
    assign fetch_halt_area = z_to_pc({fetch_addr_i[14:0], 1'b0}) >=
        flash_self_prog_pkg::HALT_START;
    assign fetch_allowed_o = fetch_halt_area || !(busy_op || blocked);

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            read_byte_o <= 8'h00;
        end else if (ce_i) begin
            read_byte_o <= read_z_i[0] ? read_word_i[15:8] : read_word_i[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status
    always_comb begin
        ctrl_rdata_o = armed;
        ctrl_rdata_o.self_prog_enable = armed.self_prog_enable || busy_op;
    end
    assign section_busy_flag_o = blocked;
    assign prog_active_o = busy_op;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_enable_busy;
        @(posedge mclk_i) busy_op |-> ctrl_rdata_o.self_prog_enable;
    endproperty
    a_enable_busy: assert property (p_enable_busy) else $error("enable low while busy");

    property p_fetch_block;
        @(posedge mclk_i) disable iff (rst_i)
        (busy_op && !fetch_halt_area) |-> !fetch_allowed_o;
    endproperty
    a_fetch_block: assert property (p_fetch_block) else $error("fetch during write");

    property p_busy_sets_flag;
        @(posedge mclk_i) disable iff (rst_i)
        (ce_i && start_prog) |=> section_busy_flag_o;
    endproperty
    a_busy_sets_flag: assert property (p_busy_sets_flag) else $error("busy flag not set");

    sequence s_started;
        ce_i && start_prog;
    endsequence
    property p_no_early_done;
        @(posedge mclk_i) s_started |=> busy_op [*2];
    endproperty
    a_no_early_done: assert property (p_no_early_done) else $error("finished too soon");

    property p_lock_refuses;
        @(posedge mclk_i) disable iff (rst_i)
        (store_i && locked) |-> !start_prog;
    endproperty
    a_lock_refuses: assert property (p_lock_refuses) else $error("locked write started");

    property p_page_taken;
        @(posedge mclk_i) (ce_i && start_prog) |=> flash_page_o == $past(store_req_i.z[13:7]);
    endproperty
    a_page_taken: assert property (p_page_taken) else $error("wrong page");

    property p_reenable_clears;
        @(posedge mclk_i) disable iff (rst_i)
        (ce_i && go && op == flash_self_prog_pkg::OP_REENABLE && !busy_op)
            |=> !section_busy_flag_o;
    endproperty
    a_reenable_clears: assert property (p_reenable_clears) else $error("no re-enable");

    property p_eeprom_wait;
        @(posedge mclk_i) eeprom_write_busy_i |-> !start_prog && !fill;
    endproperty
    a_eeprom_wait: assert property (p_eeprom_wait) else $error("store during eeprom");

    property p_reset_keeps;
        @(posedge mclk_i) (rst_i && busy_op && !timer_done && ce_i) |=> busy_op;
    endproperty
    a_reset_keeps: assert property (p_reset_keeps) else $error("reset aborted write");

    property p_no_arm;
        @(posedge mclk_i) (store_i && !arm_live) |-> store_refused_o;
    endproperty
    a_no_arm: assert property (p_no_arm) else $error("store not armed");

    sequence s_arm_write;
        ce_i && ctrl_wr_i && ctrl_wdata_i.self_prog_enable && !busy_op;
    endsequence
    property p_arm_take;
        @(posedge mclk_i) disable iff (rst_i) s_arm_write |=> arm_live;
    endproperty
    a_arm_take: assert property (p_arm_take) else $error("arming lost");

    property p_arm_lapse;
        @(posedge mclk_i) disable iff (rst_i)
        (ce_i && !ctrl_wr_i && !store_i && arm_cnt == 3'h1) |=> !arm_live;
    endproperty
    a_arm_lapse: assert property (p_arm_lapse) else $error("arming kept");

    property p_one_op;
        @(posedge mclk_i) !(flash_erase_o && flash_write_o);
    endproperty
    a_one_op: assert property (p_one_op) else $error("erase and write together");

    property p_odd_z;
        @(posedge mclk_i) (store_i && store_req_i.z[0]) |-> !start_prog && !fill;
    endproperty
    a_odd_z: assert property (p_odd_z) else $error("odd z store taken");

    property p_busy_refuse;
        @(posedge mclk_i) (store_i && busy_op) |-> store_refused_o;
    endproperty
    a_busy_refuse: assert property (p_busy_refuse) else $error("store while busy");

    property p_done;
        @(posedge mclk_i) (ce_i && timer_done) |=> !busy_op && !flash_erase_o && !flash_write_o;
    endproperty
    a_done: assert property (p_done) else $error("operation not ended");

    property p_byte;
        @(posedge mclk_i) disable iff (rst_i)
        ce_i |=> read_byte_o == ($past(read_z_i[0]) ? $past(read_word_i[15:8])
            : $past(read_word_i[7:0]));
    endproperty
    a_byte: assert property (p_byte) else $error("wrong byte");

    property p_flag_hold;
        @(posedge mclk_i) disable iff (rst_i)
        (section_busy_flag_o && !(go && op == flash_self_prog_pkg::OP_REENABLE))
            |=> section_busy_flag_o;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");

    property p_fill;
        @(posedge mclk_i) (ce_i && fill) |=> u_buf.mem[$past(word_sel)] == $past(store_req_i.data);
    endproperty
    a_fill: assert property (p_fill) else $error("buffer not filled");

    property p_index;
        @(posedge mclk_i) disable iff (rst_i)
        (ce_i && start_prog && op == flash_self_prog_pkg::OP_WRITE) |=> buf_word_o == 6'h00;
    endproperty
    a_index: assert property (p_index) else $error("write index not cleared");

    property p_halt_fetch;
        @(posedge mclk_i) fetch_halt_area |-> fetch_allowed_o;
    endproperty
    a_halt_fetch: assert property (p_halt_fetch) else $error("halting area blocked");
endmodule : flash_self_programming_ctrl

// ==== logic/page_buffer_mem.sv ====
// Temporary page buffer with registered read data
module page_buffer_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    // Clock
    input wire logic mclk_i,
    input wire logic ce_i,
    // Write port
    input wire logic wr_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    // Read port
    input wire logic [AW-1:0] raddr_i,
    output logic [WIDTH-1:0] rdata_o
);
    initial begin
        if (DEPTH != (1 << AW)) begin
            $error("page_buffer_mem depth must equal 2**AW");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge mclk_i) begin
        if (ce_i && wr_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (ce_i) begin
            rdata_o <= mem[raddr_i];
        end
    end
endmodule : page_buffer_mem

// ==== logic/rc_prog_timer.sv ====
// Programming duration timer counted on the RC oscillator tick
module rc_prog_timer #(
    parameter int TICKS = 3700
) (
    // Clock
    input wire logic mclk_i,
    input wire logic ce_i,
    // Control
    input wire logic start_i,
    input wire logic rc_tick_i,
    output logic done_o
);
    initial begin
        if (TICKS < 2) begin
            $error("rc_prog_timer needs at least two ticks");
        end
    end

    logic [31:0] cnt = 32'h0000_0000;
    logic running = 1'b0;

    // Not reset: a started operation finishes across reset
    always_ff @(posedge mclk_i) begin
        if (ce_i) begin
            if (start_i) begin
                cnt <= 32'h0000_0000;
                running <= 1'b1;
            end else if (running && rc_tick_i) begin
                if (cnt == 32'(TICKS - 1)) begin
                    running <= 1'b0;
                end
                cnt <= cnt + 32'h0000_0001;
            end
        end
    end

    assign done_o = running && rc_tick_i && (cnt == 32'(TICKS - 1));
endmodule : rc_prog_timer
